// [pkg/ccao_pkg.sv]
/*
 Constants, opcode patterns, register map and types for the add and control
 execute unit. Assumes a single 50 MHz core clock and an AXI4-Lite master.
*/
// ==========================================================================
// Package
package ccao_pkg;
   // Register map, byte addresses
   localparam int ADDR_W = 8;
   localparam logic [7:0] OFF_INSTR = 8'h00;
   localparam logic [7:0] OFF_W = 8'h04;
   localparam logic [7:0] OFF_STATUS = 8'h08;
   localparam logic [7:0] OFF_FADDR = 8'h0C;
   localparam logic [7:0] OFF_FDATA = 8'h10;
   localparam logic [7:0] OFF_PC = 8'h14;
   localparam logic [7:0] OFF_RET = 8'h18;
   localparam logic [7:0] OFF_SHADOW = 8'h1C;
   localparam logic [7:0] OFF_DPTR = 8'h20;
   localparam logic [7:0] OFF_SPEED = 8'h24;
   localparam logic [7:0] OFF_MADDR = 8'h28;
   localparam logic [7:0] OFF_CTRL = 8'h2C;
   // Status fields
   localparam int ST_C = 0;
   localparam int ST_DCY = 1;
   localparam int ST_Z = 2;
   localparam int ST_PA = 5;
   // Control register fields
   localparam int CT_BUSY = 0;
   localparam int CT_BRK = 1;
   localparam int CT_SKIP = 2;
   localparam int CT_RLIT = 4;
   localparam int CT_EXT = 8;
   localparam int CT_ERASE = 16;
   // Reset values
   localparam logic [7:0] W_RST = 8'h00;
   localparam logic [7:0] STATUS_RST = 8'h00;
   localparam logic [7:0] SPEED_RST = 8'h00;
   localparam logic [15:0] DPTR_RST = 16'h0000;
   localparam logic [15:0] MADDR_RST = 16'h0000;
   localparam logic [12:0] PC_RST = 13'h0000;
   localparam logic [12:0] INT_VEC = 13'h0010;
   // File address that aliases the program counter low byte
   localparam logic [8:0] PC_LOW_FOP = 9'h002;
   // Timing and step sizes
   localparam int ADD_CYCLES = 1;
   localparam int JUMP_CYCLES = 3;
   localparam logic [7:0] ADDR_STEP = 8'h02;
   localparam int BLOCK_WORDS = 256;
   // Opcode care masks
   localparam logic [15:0] MSK_ALL = 16'hFFFF;
   localparam logic [15:0] MSK_FOP = 16'hFE00;
   localparam logic [15:0] MSK_K8 = 16'hFF00;
   localparam logic [15:0] MSK_K3 = 16'hFFF8;
   localparam logic [15:0] MSK_A13 = 16'hE000;
   // Opcode values
   localparam logic [15:0] OPV_NOP = 16'h0000;
   localparam logic [15:0] OPV_BRK = 16'h0001;
   localparam logic [15:0] OPV_RETNP = 16'h0002;
   localparam logic [15:0] OPV_FERASE = 16'h0003;
   localparam logic [15:0] OPV_BRKX = 16'h0005;
   localparam logic [15:0] OPV_INT = 16'h0006;
   localparam logic [15:0] OPV_RET = 16'h0007;
   localparam logic [15:0] OPV_RETI = 16'h0008;
   localparam logic [15:0] OPV_PAGE = 16'h0010;
   localparam logic [15:0] OPV_IREAD = 16'h0019;
   localparam logic [15:0] OPV_IWRITE = 16'h001A;
   localparam logic [15:0] OPV_FREAD = 16'h001B;
   localparam logic [15:0] OPV_IWRITEI = 16'h001C;
   localparam logic [15:0] OPV_IREADI = 16'h001D;
   localparam logic [15:0] OPV_FWRITE = 16'h001E;
   localparam logic [15:0] OPV_SPEED = 16'h0100;
   localparam logic [15:0] OPV_LOADH = 16'h7100;
   localparam logic [15:0] OPV_LOADL = 16'h7200;
   localparam logic [15:0] OPV_ADD_WK = 16'h7B00;
   localparam logic [15:0] OPV_RETW = 16'h7C00;
   localparam logic [15:0] OPV_ADD_WF = 16'h1C00;
   localparam logic [15:0] OPV_ADD_FW = 16'h1E00;
   localparam logic [15:0] OPV_CALL = 16'hC000;
   localparam logic [15:0] OPV_JMP = 16'hE000;
   // Bus answers
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [4:0] {
      OP_NOP, OP_BRK, OP_BRKX, OP_RET, OP_RETNP, OP_RETI, OP_RETW, OP_INT,
      OP_CALL, OP_JMP, OP_FERASE, OP_MEM, OP_MEMI, OP_LOADH, OP_LOADL,
      OP_PAGE, OP_SPEED, OP_ADD_FW, OP_ADD_WF, OP_ADD_WK, OP_BAD
   } ccao_op_t;
endpackage : ccao_pkg

// [design/ccao_add8.sv]
/*
 Byte adder with carry, digit carry and zero outputs.
 Assumes purely combinational use inside the execute unit.
*/
`timescale 1ns/1ns
// ==========================================================================
// Adder
module ccao_add8 (
   input logic [7:0] a,
   input logic [7:0] b,
   output logic [7:0] sum,
   output logic carry,
   output logic digit_carry_flag,
   output logic zero
);
   logic [8:0] full;
   logic [4:0] low;

   // Full and nibble sums
   assign full = {1'b0, a} + {1'b0, b};
   assign low = {1'b0, a[3:0]} + {1'b0, b[3:0]};
   // Flags from the two sums
   assign sum = full[7:0];
   assign carry = full[8];
   assign digit_carry_flag = low[4];
   assign zero = (full[7:0] == 8'h00); // 0x100 counts as zero
endmodule : ccao_add8

// [design/ccao_core.sv]
/*
 Execute unit for the addition forms and the program and system control
 instructions, with its architectural state reached over AXI4-Lite.
 Assumes one 50 MHz clock, synchronous active-low reset, a well-behaved
 AXI4-Lite master, and that flash and external memory sit elsewhere.
*/
// Notes on behaviour
// - Add-to-file form: file register gets W plus file, W stays.
// - Add-to-W form: W gets W plus file register, file register stays.
// - Add-literal form: W gets W plus the instruction low byte.
// - Carry set when unsigned sum exceeds 0xFF; only low eight bits stored.
// - Digit carry set on carry out of bit 3 into bit 4.
// - Zero set when stored byte is zero, a sum of 0x100 included.
// - Additions take one cycle; adding into program counter low byte takes three.
// - Plain return restores page bits with the counter; no-page return keeps them.
// - Return with literal loads W and restores page bits like plain return.
// - Block erase covers 256 flash words and leaves flags alone.
// - Incrementing memory read and write add two to the address low byte.
// - Pointer loads put their byte into high or low data pointer byte.
// - Page instruction copies its three-bit operand into the page bits.
// - Rate instruction writes its byte into the core rate register, flags kept.
// - Two breakpoints; the extended one carries a pending skip across itself.
// - Interrupt return restores all flags; call, jump, int, nop keep them.
`timescale 1ns/1ns
module ccao_core
   import ccao_pkg::*;
#(
   parameter int FILE_DEPTH = 512
) (
   input logic aclk,
   input logic aresetn,
   input logic [ADDR_W-1:0] s_axi_awaddr,
   input logic [2:0] s_axi_awprot,
   input logic s_axi_awvalid,
   output logic s_axi_awready,
   input logic [31:0] s_axi_wdata,
   input logic [3:0] s_axi_wstrb,
   input logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input logic s_axi_bready,
   input logic [ADDR_W-1:0] s_axi_araddr,
   input logic [2:0] s_axi_arprot,
   input logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input logic s_axi_rready
);
   localparam int FILE_AW = $clog2(FILE_DEPTH);

   // ========================================================================
   // Elaboration checks
   if (FILE_DEPTH < 16 || FILE_DEPTH > 512 || (1 << FILE_AW) != FILE_DEPTH) begin
      $error("FILE_DEPTH must be a power of two from 16 to 512");
   end

   // ========================================================================
   // Functions
   // Opcode match under a care mask
   function automatic logic hit(input logic [15:0] i, input logic [15:0] m,
                                input logic [15:0] v);
      return (i & m) == v;
   endfunction : hit

   // Instruction word to operation
   function automatic ccao_op_t dec(input logic [15:0] i);
      if (hit(i, MSK_FOP, OPV_ADD_FW)) return OP_ADD_FW;
      if (hit(i, MSK_FOP, OPV_ADD_WF)) return OP_ADD_WF;
      if (hit(i, MSK_K8, OPV_ADD_WK)) return OP_ADD_WK;
      if (hit(i, MSK_ALL, OPV_NOP)) return OP_NOP;
      if (hit(i, MSK_ALL, OPV_BRK)) return OP_BRK;
      if (hit(i, MSK_ALL, OPV_BRKX)) return OP_BRKX;
      if (hit(i, MSK_ALL, OPV_RET)) return OP_RET;
      if (hit(i, MSK_ALL, OPV_RETNP)) return OP_RETNP;
      if (hit(i, MSK_K3, OPV_RETI)) return OP_RETI;
      if (hit(i, MSK_K8, OPV_RETW)) return OP_RETW;
      if (hit(i, MSK_ALL, OPV_INT)) return OP_INT;
      if (hit(i, MSK_A13, OPV_CALL)) return OP_CALL;
      if (hit(i, MSK_A13, OPV_JMP)) return OP_JMP;
      if (hit(i, MSK_ALL, OPV_FERASE)) return OP_FERASE;
      if (hit(i, MSK_ALL, OPV_IREADI) || hit(i, MSK_ALL, OPV_IWRITEI)) return OP_MEMI;
      if (hit(i, MSK_ALL, OPV_IREAD) || hit(i, MSK_ALL, OPV_IWRITE) ||
          hit(i, MSK_ALL, OPV_FREAD) || hit(i, MSK_ALL, OPV_FWRITE)) return OP_MEM;
      if (hit(i, MSK_K8, OPV_LOADH)) return OP_LOADH;
      if (hit(i, MSK_K8, OPV_LOADL)) return OP_LOADL;
      if (hit(i, MSK_K3, OPV_PAGE)) return OP_PAGE;
      if (hit(i, MSK_K8, OPV_SPEED)) return OP_SPEED;
      return OP_BAD;
   endfunction : dec

   // Byte-lane merge of a write into an old word
   function automatic logic [31:0] merge(input logic [31:0] old,
                                         input logic [31:0] d,
                                         input logic [3:0] s);
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++) begin
         if (s[b]) r[8*b+:8] = d[8*b+:8];
      end
      return r;
   endfunction : merge

   // ========================================================================
   // State
   logic [15:0] instr_reg, instr_next;
   logic [7:0] w_reg, w_next;
   logic [7:0] status_reg, status_next;
   logic [8:0] faddr_reg, faddr_next;
   logic [12:0] pc_reg, pc_next;
   logic [12:0] ret_reg, ret_next;
   logic [7:0] shadow_reg, shadow_next;
   logic [15:0] dptr_reg, dptr_next;
   logic [7:0] speed_reg, speed_next;
   logic [15:0] maddr_reg, maddr_next;
   logic skip_reg, skip_next;
   logic brk_reg, brk_next;
   logic [2:0] rlit_reg, rlit_next;
   logic [3:0] ext_reg, ext_next;
   logic [7:0] erase_reg, erase_next;
   logic [1:0] busy_reg, busy_next;
   logic bvalid_reg, rvalid_reg;
   logic [1:0] bresp_reg, rresp_reg;
   logic [31:0] rdata_reg;
   logic [7:0] fmem [FILE_DEPTH];

   // ========================================================================
   // Register read view
   function automatic logic [31:0] regval(input logic [5:0] idx);
      case (idx)
         OFF_INSTR[7:2]: return {16'h0000, instr_reg};
         OFF_W[7:2]: return {24'h000000, w_reg};
         OFF_STATUS[7:2]: return {24'h000000, status_reg};
         OFF_FADDR[7:2]: return {23'h000000, faddr_reg};
         OFF_FDATA[7:2]: return {24'h000000, fmem[faddr_reg[FILE_AW-1:0]]};
         OFF_PC[7:2]: return {19'h00000, pc_reg};
         OFF_RET[7:2]: return {19'h00000, ret_reg};
         OFF_SHADOW[7:2]: return {24'h000000, shadow_reg};
         OFF_DPTR[7:2]: return {16'h0000, dptr_reg};
         OFF_SPEED[7:2]: return {24'h000000, speed_reg};
         OFF_MADDR[7:2]: return {16'h0000, maddr_reg};
         OFF_CTRL[7:2]: return {8'h00, erase_reg, 4'h0, ext_reg, 1'b0, rlit_reg,
                                1'b0, skip_reg, brk_reg, busy_reg != 2'h0};
         default: return 32'h00000000;
      endcase
   endfunction : regval

   // Mapped words lie at or below the control register
   function automatic logic mapped(input logic [7:0] a);
      return a <= OFF_CTRL;
   endfunction : mapped

   // ========================================================================
   // Bus handshakes and decode
   wire busy = (busy_reg != 2'h0);
   // Address and data are taken together; a pending answer or a jump stalls
   wire wr_go = s_axi_awvalid && s_axi_wvalid && !bvalid_reg && !busy;
   wire rd_go = s_axi_arvalid && !rvalid_reg;
   wire [5:0] aw_idx = s_axi_awaddr[7:2];
   wire [5:0] ar_idx = s_axi_araddr[7:2];
   wire wr_ok = wr_go && mapped(s_axi_awaddr);
   logic [31:0] wr_old;
   // A process, so register changes inside the function re-evaluate the old word
   always_comb wr_old = regval(aw_idx);
   wire [31:0] wmrg = merge(wr_old, s_axi_wdata, s_axi_wstrb);
   assign s_axi_awready = wr_go;
   assign s_axi_wready = wr_go;
   assign s_axi_arready = rd_go;
   assign s_axi_bvalid = bvalid_reg;
   assign s_axi_bresp = bresp_reg;
   assign s_axi_rvalid = rvalid_reg;
   assign s_axi_rresp = rresp_reg;
   assign s_axi_rdata = rdata_reg;

   // Per-register write selects
   wire wr_instr = wr_ok && aw_idx == OFF_INSTR[7:2];
   wire wr_fdata = wr_ok && aw_idx == OFF_FDATA[7:2];
   wire wr_ctrl = wr_ok && aw_idx == OFF_CTRL[7:2];

   // ========================================================================
   // Instruction decode and operands
   wire [15:0] iword = wmrg[15:0];
   wire ccao_op_t op = dec(iword);
   wire [8:0] fop_sel = iword[8:0];
   wire fop_is_pc_lo = (fop_sel == PC_LOW_FOP);
   // Program counter low byte reads through the file space
   wire [7:0] fop_val = fop_is_pc_lo ? pc_reg[7:0] : fmem[fop_sel[FILE_AW-1:0]];
   // A pending skip swallows every instruction except the extended breakpoint
   wire skipped = skip_reg && op != OP_BRKX;
   wire exec = wr_instr && !skipped;
   wire is_add = (op == OP_ADD_FW) || (op == OP_ADD_WF) || (op == OP_ADD_WK);
   wire pc_lo_dst = (op == OP_ADD_FW) && fop_is_pc_lo;
   wire [7:0] add_a = w_reg;
   wire [7:0] add_b = (op == OP_ADD_WK) ? iword[7:0] : fop_val;
   wire [7:0] sum8;
   wire add_c, add_dcy, add_z;
   wire [12:0] pc_inc = pc_reg + 13'h0001;

   ccao_add8 u_add (
      .a(add_a),
      .b(add_b),
      .sum(sum8),
      .carry(add_c),
      .digit_carry_flag(add_dcy),
      .zero(add_z)
   );

   // File write port: software data window or add-to-file result
   wire fm_we = wr_fdata || (exec && op == OP_ADD_FW && !fop_is_pc_lo);
   wire [FILE_AW-1:0] fm_idx = wr_fdata ? faddr_reg[FILE_AW-1:0] : fop_sel[FILE_AW-1:0];
   wire [7:0] fm_d = wr_fdata ? wmrg[7:0] : sum8;

   // Break flag: a new break wins over a write-one clear
   wire brk_set = exec && (op == OP_BRK || op == OP_BRKX);
   assign brk_next = brk_set || (brk_reg && !(wr_ctrl && s_axi_wstrb[0] &&
                                               s_axi_wdata[CT_BRK]));

   // ========================================================================
   // Next state: software writes, then the instruction effects
   always_comb begin
      instr_next = instr_reg;
      w_next = w_reg;
      status_next = status_reg;
      faddr_next = faddr_reg;
      pc_next = pc_reg;
      ret_next = ret_reg;
      shadow_next = shadow_reg;
      dptr_next = dptr_reg;
      speed_next = speed_reg;
      maddr_next = maddr_reg;
      skip_next = skip_reg;
      rlit_next = rlit_reg;
      ext_next = ext_reg;
      erase_next = erase_reg;
      busy_next = busy ? busy_reg - 2'h1 : 2'h0;
      if (wr_ok) begin
         case (aw_idx)
            OFF_W[7:2]: w_next = wmrg[7:0];
            OFF_STATUS[7:2]: status_next = wmrg[7:0];
            OFF_FADDR[7:2]: faddr_next = wmrg[8:0];
            OFF_PC[7:2]: pc_next = wmrg[12:0];
            OFF_RET[7:2]: ret_next = wmrg[12:0];
            OFF_SHADOW[7:2]: shadow_next = wmrg[7:0];
            OFF_MADDR[7:2]: maddr_next = wmrg[15:0];
            OFF_CTRL[7:2]: skip_next = wmrg[CT_SKIP];
            default: ;
         endcase
      end
      if (wr_instr) begin
         instr_next = iword;
         pc_next = pc_inc;
         if (skipped) skip_next = 1'b0;
      end
      // Flags are left alone unless an arm below names them
      if (exec) begin
         case (op)
            OP_ADD_FW, OP_ADD_WF, OP_ADD_WK: begin
               status_next[ST_C] = add_c;
               status_next[ST_DCY] = add_dcy;
               status_next[ST_Z] = add_z;
               if (op != OP_ADD_FW) w_next = sum8;
               if (pc_lo_dst) begin
                  // Jump within the current 256-word span
                  pc_next = {pc_reg[12:8], sum8};
                  busy_next = 2'(JUMP_CYCLES - ADD_CYCLES);
               end
            end
            OP_RET: begin
               pc_next = ret_reg;
               status_next[ST_PA+:3] = ret_reg[12:10];
            end
            OP_RETNP: pc_next = ret_reg;
            OP_RETW: begin
               pc_next = ret_reg;
               w_next = iword[7:0];
               status_next[ST_PA+:3] = ret_reg[12:10];
            end
            OP_RETI: begin
               pc_next = ret_reg;
               status_next = shadow_reg;
               rlit_next = iword[2:0];
            end
            OP_INT: begin
               ret_next = pc_inc;
               shadow_next = status_reg;
               pc_next = INT_VEC;
            end
            OP_CALL: begin
               ret_next = pc_inc;
               pc_next = iword[12:0];
            end
            OP_JMP: pc_next = iword[12:0];
            OP_FERASE: begin
               // Whole block of BLOCK_WORDS words picked by the high address
               erase_next = maddr_reg[15:8];
               ext_next = iword[3:0];
            end
            OP_MEM: ext_next = iword[3:0];
            OP_MEMI: begin
               ext_next = iword[3:0];
               maddr_next[7:0] = maddr_reg[7:0] + ADDR_STEP;
            end
            OP_LOADH: dptr_next[15:8] = iword[7:0];
            OP_LOADL: dptr_next[7:0] = iword[7:0];
            OP_PAGE: status_next[ST_PA+:3] = iword[2:0];
            OP_SPEED: speed_next = iword[7:0];
            default: ;
         endcase
      end
   end

   // ========================================================================
   // Architectural registers
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         instr_reg <= 16'h0000;
         w_reg <= W_RST;
         status_reg <= STATUS_RST;
         faddr_reg <= 9'h000;
         pc_reg <= PC_RST;
         ret_reg <= PC_RST;
         shadow_reg <= STATUS_RST;
         dptr_reg <= DPTR_RST;
         speed_reg <= SPEED_RST;
         maddr_reg <= MADDR_RST;
         skip_reg <= 1'b0;
         brk_reg <= 1'b0;
         rlit_reg <= 3'h0;
         ext_reg <= 4'h0;
         erase_reg <= 8'h00;
         busy_reg <= 2'h0;
      end else begin
         instr_reg <= instr_next;
         w_reg <= w_next;
         status_reg <= status_next;
         faddr_reg <= faddr_next;
         pc_reg <= pc_next;
         ret_reg <= ret_next;
         shadow_reg <= shadow_next;
         dptr_reg <= dptr_next;
         speed_reg <= speed_next;
         maddr_reg <= maddr_next;
         skip_reg <= skip_next;
         brk_reg <= brk_next;
         rlit_reg <= rlit_next;
         ext_reg <= ext_next;
         erase_reg <= erase_next;
         busy_reg <= busy_next;
      end
   end

   // File storage, no reset: contents are software's to initialise
   always_ff @(posedge aclk) begin
      if (fm_we) fmem[fm_idx] <= fm_d;
   end

   // ========================================================================
   // Bus answers, one cycle after the request is taken
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bvalid_reg <= 1'b0;
         bresp_reg <= RESP_OKAY;
         rvalid_reg <= 1'b0;
         rresp_reg <= RESP_OKAY;
         rdata_reg <= 32'h00000000;
      end else begin
         if (wr_go) begin
            bvalid_reg <= 1'b1;
            bresp_reg <= wr_ok ? RESP_OKAY : RESP_SLVERR;
         end else if (s_axi_bready) begin
            bvalid_reg <= 1'b0;
         end
         if (rd_go) begin
            rvalid_reg <= 1'b1;
            rresp_reg <= mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
            rdata_reg <= regval(ar_idx);
         end else if (s_axi_rready) begin
            rvalid_reg <= 1'b0;
         end
      end
   end

   // ========================================================================
   // Assertions
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   a_add_file_sum:
   assert property (exec && op == OP_ADD_FW && !fop_is_pc_lo |=>
                    fmem[$past(fm_idx)] == 8'($past(add_a) + $past(add_b)) &&
                    w_reg == $past(w_reg))
      else $error("add-to-file result or W wrong");
   a_add_w_sum:
   assert property (exec && op == OP_ADD_WF |=>
                    w_reg == 8'($past(w_reg) + $past(fop_val)))
      else $error("add-to-W result wrong");
   a_add_lit_sum:
   assert property (exec && op == OP_ADD_WK |=>
                    w_reg == 8'($past(w_reg) + $past(iword[7:0])))
      else $error("add-literal result wrong");
   a_carry_flag:
   assert property (exec && is_add |=> status_reg[ST_C] ==
                    (({1'b0, $past(add_a)} + {1'b0, $past(add_b)}) > 9'h0FF))
      else $error("carry flag wrong");
   a_digit_carry:
   assert property (exec && is_add |=> status_reg[ST_DCY] ==
                    (({1'b0, $past(add_a[3:0])} + {1'b0, $past(add_b[3:0])}) > 5'h0F))
      else $error("digit carry flag wrong");
   a_zero_flag:
   assert property (exec && is_add |=> status_reg[ST_Z] ==
                    (8'($past(add_a) + $past(add_b)) == 8'h00))
      else $error("zero flag wrong");
   a_jump_cycles:
   assert property (exec && pc_lo_dst |=> busy [*2] ##1 !busy)
      else $error("low-byte jump not three cycles");
   a_ret_page:
   assert property (exec && op == OP_RET |=> pc_reg == $past(ret_reg) &&
                    status_reg[ST_PA+:3] == $past(ret_reg[12:10]))
      else $error("return did not restore page bits");
   a_retnp_keep:
   assert property (exec && op == OP_RETNP |=> status_reg == $past(status_reg))
      else $error("no-page return changed status");
   a_addr_step:
   assert property (exec && op == OP_MEMI |=>
                    maddr_reg[7:0] == 8'($past(maddr_reg[7:0]) + 8'h02))
      else $error("address low byte not stepped by two");
   a_speed_load:
   assert property (exec && op == OP_SPEED |=> speed_reg == $past(iword[7:0]) &&
                    $stable(status_reg))
      else $error("rate load wrong or flags touched");
endmodule : ccao_core

// [verification/ccao_tb_top.sv]
/*
 Self-checking bench for the add and control execute unit.
 Assumes ccao_pkg and ccao_core are compiled first; drives AXI4-Lite itself.
*/
`timescale 1ns/1ns
// ==========================================================================
// Bench top
module cpu_add_and_control_ops_tb_top;
   import ccao_pkg::*;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic awv = 1'b0;
   logic wv = 1'b0;
   logic arv = 1'b0;
   logic [7:0] awa = 8'h00;
   logic [7:0] ara = 8'h00;
   logic [31:0] wd = 32'h0;
   logic [31:0] rd, got;
   logic awr, wrdy, bv, arr, rv;
   logic [1:0] br, rr, gresp;
   int bad_count = 0;
   int checks_done = 0;
   logic [7:0] w, f, k, st, s;
   logic [8:0] fa;
   logic c, dcy, z;
   // Clock at 50 MHz
   always #10 aclk = ~aclk;
   // Ready lines held high, so every answer is taken on its first edge
   ccao_core DUT (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa), .s_axi_awprot(3'h0),
      .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hF),
      .s_axi_wvalid(wv), .s_axi_wready(wrdy), .s_axi_bresp(br), .s_axi_bvalid(bv),
      .s_axi_bready(1'b1), .s_axi_araddr(ara), .s_axi_arprot(3'h0), .s_axi_arvalid(arv),
      .s_axi_arready(arr), .s_axi_rdata(rd), .s_axi_rresp(rr), .s_axi_rvalid(rv),
      .s_axi_rready(1'b1));
   // ========================================================================
   // Bus tasks and comparison
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      awa <= a;
      wd <= d;
      awv <= 1'b1;
      wv <= 1'b1;
      do @(posedge aclk); while (awr !== 1'b1);
      awv <= 1'b0;
      wv <= 1'b0;
      do @(posedge aclk); while (bv !== 1'b1);
      gresp = br;
   endtask : wr
   task automatic rdv(input logic [7:0] a);
      ara <= a;
      arv <= 1'b1;
      do @(posedge aclk); while (arr !== 1'b1);
      arv <= 1'b0;
      do @(posedge aclk); while (rv !== 1'b1);
      got = rd;
      gresp = rr;
   endtask : rdv
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      checks_done++;
      if (g !== e) begin
         bad_count++;
         $display("[ERR] %s expected %h seen %h", n, e, g);
      end
   endtask : chk
   task automatic rchk(input logic [7:0] a, input logic [31:0] e, input string n);
      rdv(a);
      chk(n, e, got);
   endtask : rchk
   // Expected {carry, digit carry, zero, byte}, nibble carry kept apart
   function automatic logic [10:0] add_exp(input logic [7:0] a, input logic [7:0] b);
      logic [8:0] t;
      t = {1'b0, a} + {1'b0, b};
      return {t[8], ({1'b0, a[3:0]} + {1'b0, b[3:0]}) > 5'd15, t[7:0] == 8'h00, t[7:0]};
   endfunction : add_exp
   task automatic final_report;
      $display("checks %0d mismatches %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : final_report
   // ========================================================================
   // Watchdog, far beyond the few hundred cycles the tests need
   initial begin
      #1000000;
      bad_count++;
      final_report();
   end
   // ========================================================================
   // Main sequence: three forms rotate, first pass sums to 0x100
   initial begin
      void'($urandom(4756));
      repeat (5) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      for (int i = 0; i < 30; i++) begin
         {w, f, k, st} = (i < 3) ? 32'h88787800 : $urandom;
         fa = 9'h003 + 9'($urandom % 500);
         wr(OFF_W, {24'h0, w});
         wr(OFF_FADDR, {23'h0, fa});
         wr(OFF_FDATA, {24'h0, f});
         wr(OFF_STATUS, {24'h0, st});
         {c, dcy, z, s} = add_exp(w, (i % 3 == 2) ? k : f);
         if (i % 3 == 0) wr(OFF_INSTR, {16'h0, OPV_ADD_FW | {7'h0, fa}});
         else if (i % 3 == 1) wr(OFF_INSTR, {16'h0, OPV_ADD_WF | {7'h0, fa}});
         else wr(OFF_INSTR, {16'h0, OPV_ADD_WK | {8'h0, k}});
         rchk(OFF_W, {24'h0, (i % 3 == 0) ? w : s}, "w");
         rchk(OFF_FDATA, {24'h0, (i % 3 == 0) ? s : f}, "file");
         rchk(OFF_STATUS, {24'h0, st[7:3], z, dcy, c}, "status");
      end
      // Add into the counter low byte: jumps, busy still up two edges later
      wr(OFF_PC, 32'h1234);
      wr(OFF_W, 32'h10);
      wr(OFF_INSTR, {16'h0, OPV_ADD_FW | {7'h0, PC_LOW_FOP}});
      rchk(OFF_CTRL, 32'h1, "jump busy");
      rchk(OFF_PC, 32'h1244, "jump pc");
      $display("test adds done");
      wr(OFF_STATUS, 32'h18);
      wr(OFF_RET, 32'h1A55);
      wr(OFF_INSTR, {16'h0, OPV_RETNP});
      rchk(OFF_STATUS, 32'h18, "retnp page");
      wr(OFF_INSTR, {16'h0, OPV_RET});
      rchk(OFF_PC, 32'h1A55, "ret pc");
      rchk(OFF_STATUS, 32'hD8, "ret page");
      wr(OFF_INSTR, {16'h0, OPV_PAGE | 16'h0003});
      rchk(OFF_STATUS, 32'h78, "page");
      wr(OFF_INSTR, {16'h0, OPV_RETW | 16'h00A5});
      rchk(OFF_W, 32'hA5, "retw w");
      rchk(OFF_STATUS, 32'hD8, "retw page");
      wr(OFF_INSTR, {16'h0, OPV_LOADH | 16'h003C});
      wr(OFF_INSTR, {16'h0, OPV_LOADL | 16'h00C3});
      rchk(OFF_DPTR, 32'h3CC3, "pointer");
      wr(OFF_INSTR, {16'h0, OPV_SPEED | 16'h005A});
      rchk(OFF_SPEED, 32'h5A, "rate");
      wr(OFF_MADDR, 32'h12FF);
      wr(OFF_INSTR, {16'h0, OPV_IREADI});
      wr(OFF_INSTR, {16'h0, OPV_IWRITEI});
      rchk(OFF_MADDR, 32'h1203, "address step");
      wr(OFF_INSTR, {16'h0, OPV_FERASE});
      wr(OFF_INSTR, {16'h0, OPV_FREAD});
      rchk(OFF_STATUS, 32'hD8, "flags kept");
      wr(OFF_SHADOW, 32'h05);
      wr(OFF_INSTR, {16'h0, OPV_RETI | 16'h0006});
      rchk(OFF_STATUS, 32'h05, "reti flags");
      wr(OFF_INSTR, {16'h0, OPV_INT});
      wr(OFF_INSTR, {16'h0, OPV_CALL | 16'h0123});
      wr(OFF_INSTR, {16'h0, OPV_JMP | 16'h0456});
      wr(OFF_INSTR, {16'h0, OPV_NOP});
      rchk(OFF_STATUS, 32'h05, "call flags");
      rchk(OFF_PC, 32'h0457, "jmp nop pc");
      // Skip pending: the extended break keeps it, the next load is dropped
      wr(OFF_CTRL, 32'h4);
      wr(OFF_INSTR, {16'h0, OPV_BRKX});
      wr(OFF_INSTR, {16'h0, OPV_LOADL | 16'h0077});
      rchk(OFF_DPTR, 32'h3CC3, "skipped load");
      wr(OFF_CTRL, 32'h2);
      rchk(OFF_CTRL, 32'h120B60, "break cleared");
      wr(OFF_INSTR, {16'h0, OPV_BRK});
      rchk(OFF_CTRL, 32'h120B62, "break");
      rdv(8'h30);
      chk("unmapped resp", {30'h0, RESP_SLVERR}, {30'h0, gresp});
      wr(8'h30, 32'h0);
      chk("unmapped wr resp", {30'h0, RESP_SLVERR}, {30'h0, gresp});
      $display("test control done");
      final_report();
   end
endmodule : cpu_add_and_control_ops_tb_top
